//--- rtl/smse_regs.vh
// Register map, field layout and code values for the mode select and enable block.
`ifndef SMSE_REGS_VH
`define SMSE_REGS_VH
`define SMSE_ADDR_W 4
`define SMSE_OFF_FUNC 4'h0
`define SMSE_OFF_CTRL 4'h4
`define SMSE_OFF_STAT 4'h8
`define SMSE_FUNC_RESET 32'h00000000
`define SMSE_MODE_LSB 4
`define SMSE_MODE_MSB 7
`define SMSE_ENSRC_LSB 12
`define SMSE_ENSRC_MSB 15
`define SMSE_CTRL_RESTART 0
`define SMSE_CTRL_ALM_CLR 1
`define SMSE_ENSRC_PIN 4'h0
`define SMSE_ENSRC_ALWAYS 4'h7
`define SMSE_M_SPEED 4'h0
`define SMSE_M_POS 4'h1
`define SMSE_M_FORCE 4'h2
`define SMSE_M_PRESET 4'h3
`define SMSE_M_PRE_SPD 4'h4
`define SMSE_M_PRE_POS 4'h5
`define SMSE_M_PRE_FRC 4'h6
`define SMSE_M_POS_SPD 4'h7
`define SMSE_M_POS_FRC 4'h8
`define SMSE_M_FRC_SPD 4'h9
`define SMSE_M_SPD_ZC 4'hA
`define SMSE_M_POS_INH 4'hB
`define SMSE_METH_SPEED 3'h0
`define SMSE_METH_POS 3'h1
`define SMSE_METH_FORCE 3'h2
`define SMSE_METH_PRESET 3'h3
`define SMSE_METH_SPD_ZC 3'h4
`define SMSE_METH_POS_INH 3'h5
`define SMSE_METH_OFF 3'h7
`define SMSE_RESP_OKAY 2'h0
`define SMSE_RESP_SLVERR 2'h2
`endif

//--- rtl/smse_sync.v
// Three-stage input synchroniser with agreement filter for a group of pins.
`timescale 1ns/10ps
module smse_sync #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      reg q;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q <= 1'b0;
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          // A change counts only once the second and third stages agree.
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign level[i] = q;
    end
  endgenerate
endmodule

//--- rtl/smse_top.v
// Control mode selection and motor enable gating with an AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "smse_regs.vh"
module smse_top (
  input wire aclk,
  input wire aresetn,
  input wire [`SMSE_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SMSE_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire motor_enable_n,
  input wire main_power_on,
  input wire safety_power_cutoff_state,
  input wire alarm_active,
  input wire motor_moving,
  input wire proportional_select_input_n,
  input wire fwd_limit_select_input_n,
  input wire rev_limit_select_input_n,
  input wire mode_switch_input_n,
  output reg motor_energize,
  output reg [2:0] active_method,
  output reg [2:0] preset_select,
  output reg preset_reverse
);
  localparam [1:0] EN_OFF = 2'h0;
  localparam [1:0] EN_WAIT = 2'h1;
  localparam [1:0] EN_ON = 2'h2;
  wire [7:0] pins;
  wire [7:0] lv;
  reg [31:0] function_select_param;
  reg [3:0] control_mode_nibble;
  reg [3:0] enable_source_nibble;
  reg alarm_latched;
  reg [1:0] en_state;
  reg [1:0] next_en_state;
  reg aw_held;
  reg w_held;
  reg [`SMSE_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] next_method;
  reg [31:0] next_func;
  reg [31:0] rd_word;
  reg [1:0] rd_resp;
  wire enable_armed;
  wire en_req;
  wire en_ok;
  wire enable_pin;
  wire power_ok;
  wire cutoff_live;
  wire alarm_live;
  wire prop_sel;
  wire sel_a;
  wire sel_b;
  wire mode_sw;
  wire wr_fire;
  wire wr_func;
  wire wr_ctrl;
  wire aw_mapped;
  wire restart_hit;
  wire alm_clr_hit;
  wire [2:0] preset_onehot;
  wire [31:0] stat_word;
  integer k;

  // Active-low pins are inverted ahead of the synchroniser, so that its cleared
  // state after reset reads as idle and no false request follows reset.
  assign pins = {~motor_enable_n,
                 main_power_on,
                 safety_power_cutoff_state,
                 alarm_active,
                 ~proportional_select_input_n,
                 ~fwd_limit_select_input_n,
                 ~rev_limit_select_input_n,
                 ~mode_switch_input_n};

  smse_sync #(
    .W(8)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(pins),
    .level(lv)
  );

  assign enable_pin = lv[7];
  assign power_ok = lv[6];
  assign cutoff_live = lv[5];
  assign alarm_live = lv[4];
  assign prop_sel = lv[3];
  assign sel_a = lv[2];
  assign sel_b = lv[1];
  assign mode_sw = lv[0];

  // Pin source or constant enable, as latched at the last restart.
  assign en_req = (enable_source_nibble == `SMSE_ENSRC_ALWAYS) ? 1'b1 :
                  (enable_source_nibble == `SMSE_ENSRC_PIN) ? enable_pin : 1'b0;
  // Power, safety cutoff and a live or latched alarm all gate acceptance of the enable.
  // The live alarm is included so that the cycle before the latch sets cannot arm.
  assign en_ok = power_ok & ~cutoff_live & ~alarm_live & ~alarm_latched;

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_func = wr_fire & (aw_addr == `SMSE_OFF_FUNC);
  assign wr_ctrl = wr_fire & (aw_addr == `SMSE_OFF_CTRL);
  assign aw_mapped = (aw_addr == `SMSE_OFF_FUNC) | (aw_addr == `SMSE_OFF_CTRL);
  assign restart_hit = wr_ctrl & w_strb[0] & w_data[`SMSE_CTRL_RESTART];
  assign alm_clr_hit = wr_ctrl & w_strb[0] & w_data[`SMSE_CTRL_ALM_CLR];

  always @* begin
    next_func = function_select_param;
    for (k = 0; k < 4; k = k + 1) begin
      if (w_strb[k]) begin
        next_func[k*8 +: 8] = w_data[k*8 +: 8];
      end
    end
  end

  // The alarm stays pending until software resets it, and a live alarm wins over the reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      alarm_latched <= 1'b0;
    end else if (alarm_live) begin
      alarm_latched <= 1'b1;
    end else if (alm_clr_hit) begin
      alarm_latched <= 1'b0;
    end
  end

  // Mode and enable source are applied only at restart, so a live drive changes method only through the mode switch input.
  always @(posedge aclk) begin
    if (!aresetn) begin
      function_select_param <= `SMSE_FUNC_RESET;
      control_mode_nibble <= `SMSE_M_SPEED;
      enable_source_nibble <= `SMSE_ENSRC_PIN;
    end else begin
      if (wr_func) begin
        function_select_param <= next_func;
      end
      if (restart_hit) begin
        control_mode_nibble <= function_select_param[`SMSE_MODE_MSB:`SMSE_MODE_LSB];
        enable_source_nibble <= function_select_param[`SMSE_ENSRC_MSB:`SMSE_ENSRC_LSB];
      end
    end
  end

  // A new enable waits while the motor moves; an accepted one is kept while it moves.
  always @* begin
    next_en_state = en_state;
    case (en_state)
      EN_OFF: begin
        if (motor_moving) begin
          next_en_state = EN_WAIT;
        end else begin
          next_en_state = EN_ON;
        end
      end
      EN_WAIT: begin
        if (!motor_moving) begin
          next_en_state = EN_ON;
        end
      end
      EN_ON: next_en_state = EN_ON;
      default: next_en_state = EN_OFF;
    endcase
    if (!en_req || !en_ok || restart_hit) begin
      next_en_state = EN_OFF;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      en_state <= EN_OFF;
    end else begin
      en_state <= next_en_state;
    end
  end

  assign enable_armed = (en_state == EN_ON);

  // Preset speed one-hot from the two select pins; none selected means zero speed.
  assign preset_onehot = {sel_b & sel_a, sel_b & ~sel_a, ~sel_b & sel_a};

  assign stat_word = {16'h0000,
                      enable_source_nibble,
                      control_mode_nibble,
                      motor_energize,
                      active_method,
                      alarm_latched,
                      cutoff_live,
                      power_ok,
                      enable_armed};

  always @* begin
    rd_resp = `SMSE_RESP_OKAY;
    case (s_axi_araddr)
      `SMSE_OFF_FUNC: rd_word = function_select_param;
      `SMSE_OFF_CTRL: rd_word = 32'h00000000;
      `SMSE_OFF_STAT: rd_word = stat_word;
      default: begin
        rd_word = 32'h00000000;
        rd_resp = `SMSE_RESP_SLVERR;
      end
    endcase
  end

  // The switch input picks the second method of each combined mode.
  always @* begin
    case (control_mode_nibble)
      `SMSE_M_SPEED: next_method = `SMSE_METH_SPEED;
      `SMSE_M_POS: next_method = `SMSE_METH_POS;
      `SMSE_M_FORCE: next_method = `SMSE_METH_FORCE;
      `SMSE_M_PRESET: next_method = `SMSE_METH_PRESET;
      `SMSE_M_PRE_SPD: next_method = mode_sw ? `SMSE_METH_SPEED : `SMSE_METH_PRESET;
      `SMSE_M_PRE_POS: next_method = mode_sw ? `SMSE_METH_POS : `SMSE_METH_PRESET;
      `SMSE_M_PRE_FRC: next_method = mode_sw ? `SMSE_METH_FORCE : `SMSE_METH_PRESET;
      `SMSE_M_POS_SPD: next_method = mode_sw ? `SMSE_METH_SPEED : `SMSE_METH_POS;
      `SMSE_M_POS_FRC: next_method = mode_sw ? `SMSE_METH_FORCE : `SMSE_METH_POS;
      `SMSE_M_FRC_SPD: next_method = mode_sw ? `SMSE_METH_SPEED : `SMSE_METH_FORCE;
      `SMSE_M_SPD_ZC: next_method = mode_sw ? `SMSE_METH_SPD_ZC : `SMSE_METH_SPEED;
      `SMSE_M_POS_INH: next_method = mode_sw ? `SMSE_METH_POS_INH : `SMSE_METH_POS;
      default: next_method = `SMSE_METH_OFF;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      motor_energize <= 1'b0;
      active_method <= `SMSE_METH_OFF;
      preset_select <= 3'h0;
      preset_reverse <= 1'b0;
    end else begin
      motor_energize <= enable_armed & en_ok & en_req;
      active_method <= next_method;
      if (next_method == `SMSE_METH_PRESET) begin
        preset_select <= preset_onehot;
        preset_reverse <= prop_sel;
      end else begin
        preset_select <= 3'h0;
        preset_reverse <= 1'b0;
      end
    end
  end

  // Write side: address and data are taken independently, the response follows both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SMSE_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`SMSE_ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_mapped ? `SMSE_RESP_OKAY : `SMSE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Read side: one cycle after the address is taken the data appear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SMSE_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_resp;
        s_axi_rdata <= rd_word;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- test/smse_chk.sv
// Concurrent checks on the ports of the mode select and enable block.
`timescale 1ns/10ps
module smse_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire main_power_on,
  input wire safety_power_cutoff_state,
  input wire alarm_active,
  input wire motor_moving,
  input wire motor_energize,
  input wire [2:0] active_method,
  input wire [2:0] preset_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Two spare cycles cover the pin synchroniser and the arming stage.
  property p_pwr; !main_power_on [*8] |-> ##2 !motor_energize; endproperty
  a_pwr: assert property (p_pwr) else $error("energized without main power");
  property p_cut; safety_power_cutoff_state [*8] |-> ##2 !motor_energize; endproperty
  a_cut: assert property (p_cut) else $error("energized during safety cutoff");
  property p_alm; alarm_active [*8] |-> ##2 !motor_energize; endproperty
  a_alm: assert property (p_alm) else $error("energized with alarm pending");
  property p_mov; motor_moving [*3] |=> !$rose(motor_energize); endproperty
  a_mov: assert property (p_mov) else $error("enable taken while moving");
  property p_meth; active_method != 3'h6; endproperty
  a_meth: assert property (p_meth) else $error("illegal method code");
  property p_pre; $onehot0(preset_select); endproperty
  a_pre: assert property (p_pre) else $error("preset select not one-hot");
  property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b: assert property (p_b) else $error("write response dropped");
  property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r: assert property (p_r) else $error("read data dropped");
endmodule
bind smse_top smse_chk u_chk (.*);

//--- test/smse_host.sv
// Host controller model driving the enable and mode switch pins.
`timescale 1ns/10ps
module smse_host (
  input wire aclk,
  input wire run,
  input wire alt,
  output reg motor_enable_n = 1'h1,
  output reg mode_switch_input_n = 1'h1,
  output reg ref_active = 1'h0
);
  // References trail the enable so the motor is never started by a reference alone.
  always @(posedge aclk) begin
    motor_enable_n <= !run;
    mode_switch_input_n <= !alt;
    ref_active <= run && !motor_enable_n;
  end
endmodule

//--- test/tb_smse_top.sv
// Self-checking bench for control mode selection and motor enable gating.
`timescale 1ns/10ps
`include "smse_regs.vh"
module tb_smse_top;
  localparam [63:0] FIR = 64'h7777102113333210;
  localparam [63:0] SEC = 64'h7777540202103210;
  logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, alt = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, q;
  logic [1:0] r;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic main_power_on = 1'h1, safety_power_cutoff_state = 1'h0, alarm_active = 1'h0, motor_moving = 1'h0;
  logic proportional_select_input_n = 1'h1, fwd_limit_select_input_n = 1'h1, rev_limit_select_input_n = 1'h1;
  wire motor_enable_n, mode_switch_input_n, ref_active, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, motor_energize, preset_reverse;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [2:0] active_method, preset_select;
  wire [31:0] s_axi_rdata;
  integer miscompares = 0, num_checks = 0;
  smse_top dut (.*);
  smse_host host (.*);
  always #5 aclk = !aclk;
  task automatic chk(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt;
    repeat (12) @(posedge aclk);
  endtask
  task automatic bus(input w, input [3:0] a, input [31:0] d, output [31:0] rd, output [1:0] rs);
    integer n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 60);
    if (n >= 60) miscompares++;
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic setf(input [31:0] v);
    bus(1'h1, `SMSE_OFF_FUNC, v, q, r);
    bus(1'h1, `SMSE_OFF_CTRL, 32'h1, q, r);
    wt;
  endtask
  task automatic t_regs;
    bus(1'h0, `SMSE_OFF_FUNC, 32'h0, q, r);
    chk(q, `SMSE_FUNC_RESET);
    bus(1'h0, 4'hC, 32'h0, q, r);
    chk(r, `SMSE_RESP_SLVERR);
    bus(1'h1, 4'hC, 32'h5A5A, q, r);
    chk(r, `SMSE_RESP_SLVERR);
    bus(1'h1, `SMSE_OFF_FUNC, 32'hA0B0, q, r);
    chk(r, `SMSE_RESP_OKAY);
    bus(1'h0, `SMSE_OFF_FUNC, 32'h0, q, r);
    chk(q, 32'hA0B0);
    chk(r, `SMSE_RESP_OKAY);
    bus(1'h0, `SMSE_OFF_CTRL, 32'h0, q, r);
    chk(q, 32'h0);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 16; m++) begin
      for (int s = 0; s < 2; s++) begin
        alt <= s[0];
        setf(m << 4);
        chk(active_method, s ? SEC[4*m +: 3] : FIR[4*m +: 3]);
      end
    end
  endtask
  task automatic t_preset;
    alt <= 1'h0;
    setf(32'h30);
    for (int k = 0; k < 8; k++) begin
      proportional_select_input_n <= !k[0];
      fwd_limit_select_input_n <= !k[1];
      rev_limit_select_input_n <= !k[2];
      wt;
      chk({preset_reverse, preset_select}, {k[0], k[2] & k[1], k[2] & !k[1], !k[2] & k[1]});
    end
  endtask
  task automatic t_enable;
    setf(32'h0);
    run <= 1'h1;
    wt;
    chk(motor_energize, 1);
    run <= 1'h0;
    motor_moving <= 1'h1;
    wt;
    chk(motor_energize, 0);
    run <= 1'h1;
    wt;
    chk(motor_energize, 0);
    motor_moving <= 1'h0;
    wt;
    chk(motor_energize, 1);
    main_power_on <= 1'h0;
    wt;
    chk(motor_energize, 0);
    main_power_on <= 1'h1;
    safety_power_cutoff_state <= 1'h1;
    wt;
    chk(motor_energize, 0);
    safety_power_cutoff_state <= 1'h0;
    alarm_active <= 1'h1;
    wt;
    alarm_active <= 1'h0;
    wt;
    chk(motor_energize, 0);
    bus(1'h1, `SMSE_OFF_CTRL, 32'h2, q, r);
    wt;
    chk(motor_energize, 1);
  endtask
  task automatic t_always;
    run <= 1'h0;
    bus(1'h1, `SMSE_OFF_FUNC, 32'h7000, q, r);
    wt;
    chk(motor_energize, 0);
    bus(1'h1, `SMSE_OFF_CTRL, 32'h1, q, r);
    wt;
    chk(motor_energize, 1);
    bus(1'h0, `SMSE_OFF_STAT, 32'h0, q, r);
    chk(q, 32'h00007083);
    main_power_on <= 1'h0;
    wt;
    chk(motor_energize, 0);
    main_power_on <= 1'h1;
    wt;
    chk(motor_energize, 1);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_regs;
    t_modes;
    t_preset;
    t_enable;
    t_always;
    tally_and_finish;
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
endmodule
